/* shared/ilk_regs_pkg.sv */
// constants, field layout and carriers for the link status and control register bank
// assumes a single management clock and an ahb-lite master issuing word transfers
// Operation
// - lane wrap bit set loops that lane back
// - no wrap function in the alternate variant
// - debug bit 9 forces lock to data, not in the alternate variant
// - debug bit 8 forces lock to reference, not in the alternate variant
// - debug bit 7 clears transmit error state
// - debug bit 6 clears receive counters, flags
// - debug register zero for normal operation
// - alignment bits 0 and 1 show live state
// - alignment bit 12 shows marker sync, pam4
// - per-lane block boundary lock vector
// - per-lane metaframe sync vector
// - saturating 4-bit per-lane checksum error counters
// - sticky receive alignment loss flag
// - sticky transmit alignment loss flag
// - set inject bit corrupts that lane's checksum
// - transmit channel ready vector, alternate only
// - receive channel ready vector, alternate only
// - bad framing flag, write zero clears, pam4 only
// - uncorrectable code-word flag, write zero clears, pam4 only
package ilk_regs_pkg;
   localparam int unsigned NUM_LANES_DEF = 32;
   localparam int unsigned MAX_LANES = 32;
   localparam int unsigned CNT_W = 4;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [7:0] IDX_WRAP = 8'h12;
   localparam logic [7:0] IDX_DBG = 8'h13;
   localparam logic [7:0] IDX_ALIGN = 8'h20;
   localparam logic [7:0] IDX_BLOCK = 8'h21;
   localparam logic [7:0] IDX_META = 8'h22;
   localparam logic [7:0] IDX_LANE_CHECKSUM_ERRORS_0 = 8'h23;
   localparam logic [7:0] IDX_LANE_CHECKSUM_ERRORS_1 = 8'h24;
   localparam logic [7:0] IDX_LANE_CHECKSUM_ERRORS_2 = 8'h25;
   localparam logic [7:0] IDX_LANE_CHECKSUM_ERRORS_3 = 8'h26;
   localparam logic [7:0] IDX_RXLOSS = 8'h28;
   localparam logic [7:0] IDX_TXLOSS = 8'h29;
   localparam logic [7:0] IDX_INJECT = 8'h38;
   localparam logic [7:0] IDX_TXRDY = 8'h40;
   localparam logic [7:0] IDX_RXRDY = 8'h41;
   localparam logic [7:0] IDX_XCODER = 8'h80;
   localparam logic [7:0] IDX_UNCOR = 8'h81;
   localparam int unsigned DBG_LOCK_DATA_BIT = 9;
   localparam int unsigned DBG_LOCK_REF_BIT = 8;
   localparam int unsigned DBG_TX_CLR_BIT = 7;
   localparam int unsigned DBG_RX_CLR_BIT = 6;
   localparam int unsigned AL_TX_BIT = 0;
   localparam int unsigned AL_RX_BIT = 1;
   localparam int unsigned AL_RS_BIT = 12;
   localparam int unsigned FLAG_BIT = 0;
   localparam logic [31:0] RST_VEC = 32'h0;
   localparam logic RST_FLAG = 1'b0;
   typedef enum logic [1:0] {
      VAR_LH = 2'b00,
      VAR_E_NRZ = 2'b01,
      VAR_E_PAM4 = 2'b10
   } variant_e;
   typedef struct packed {
      logic lock_data;
      logic lock_ref;
      logic tx_clear;
      logic rx_clear;
   } dbg_ctrl_s;
   typedef struct packed {
      logic rs_sync;
      logic rx_aligned;
      logic tx_aligned;
   } align_s;
   typedef struct packed {
      logic rx_loss;
      logic tx_loss;
      logic bad_framing;
      logic uncor;
   } event_s;
   localparam dbg_ctrl_s RST_DBG = '{default: 1'b0};
endpackage

/* rtl/ilk_status_regs.sv */
// link status and control register bank with an ahb-lite slave port
// level status inputs are asynchronous; error event pulses come from SYS_CLK logic
`timescale 1ns/1ps
module stat_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;
   // a bit moves only when the second and third stages agree
   always_comb begin
      out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end
   assign dout = out_q;
endmodule // stat_sync

module ilk_status_regs import ilk_regs_pkg::*; #(
   parameter int unsigned NUM_LANES = NUM_LANES_DEF,
   parameter variant_e VARIANT = VAR_LH
) (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire align_s ALIGN_IN,
   input wire logic [NUM_LANES-1:0] BLOCK_LOCK_IN,
   input wire logic [NUM_LANES-1:0] META_SYNC_IN,
   input wire logic [NUM_LANES-1:0] TX_CHAN_READY_IN,
   input wire logic [NUM_LANES-1:0] RX_CHAN_READY_IN,
   input wire logic [NUM_LANES-1:0] CRC_ERR_IN,
   input wire event_s EVENTS_IN,
   output logic [NUM_LANES-1:0] LANE_WRAP_EN,
   output dbg_ctrl_s DBG_CTRL,
   output logic [NUM_LANES-1:0] CRC_FAULT_INSERT
);
   localparam logic HAS_WRAP = (VARIANT == VAR_LH);
   localparam logic HAS_ETILE = (VARIANT != VAR_LH);
   localparam logic HAS_PAM4 = (VARIANT == VAR_E_PAM4);

   align_s align_s_w;
   logic [NUM_LANES-1:0] block_s, meta_s, txrdy_s, rxrdy_s;

   stat_sync #(.W(3)) u_sync_align (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .din(ALIGN_IN),
      .dout(align_s_w)
   );
   stat_sync #(.W(NUM_LANES)) u_sync_block (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .din(BLOCK_LOCK_IN),
      .dout(block_s)
   );
   stat_sync #(.W(NUM_LANES)) u_sync_meta (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .din(META_SYNC_IN),
      .dout(meta_s)
   );
   stat_sync #(.W(NUM_LANES)) u_sync_txrdy (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .din(TX_CHAN_READY_IN),
      .dout(txrdy_s)
   );
   stat_sync #(.W(NUM_LANES)) u_sync_rxrdy (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .din(RX_CHAN_READY_IN),
      .dout(rxrdy_s)
   );

   logic [NUM_LANES-1:0] wrap_q, wrap_d, inject_q, inject_d;
   dbg_ctrl_s dbg_q, dbg_d;
   logic [CNT_W-1:0] cnt_q [MAX_LANES];
   logic [CNT_W-1:0] cnt_d [MAX_LANES];
   logic rx_loss_q, rx_loss_d, tx_loss_q, tx_loss_d;
   logic xcoder_q, xcoder_d, uncor_q, uncor_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_idx_q, wr_idx_d;
   logic [31:0] rd_q, rd_d, rd_word;
   logic [127:0] crc_all;
   logic [31:0] err_pad;
   logic take, hit;
   logic [7:0] idx;

   // zero wait states: every access completes in its first data-phase cycle
   assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   assign hit = (HADDR[31:10] == 22'h0);
   assign idx = hit ? HADDR[9:2] : 8'h00;
   assign err_pad = 32'(CRC_ERR_IN);

   always_comb begin
      crc_all = '0;
      for (int i = 0; i < MAX_LANES; i++) begin
         crc_all[i*CNT_W +: CNT_W] = cnt_q[i];
      end
   end

   // read data is registered at the address phase; unmapped words read zero
   always_comb begin
      rd_word = RST_VEC;
      if (idx == IDX_WRAP) begin
         rd_word = HAS_WRAP ? 32'(wrap_q) : RST_VEC;
      end else if (idx == IDX_DBG) begin
         rd_word[DBG_LOCK_DATA_BIT] = dbg_q.lock_data;
         rd_word[DBG_LOCK_REF_BIT] = dbg_q.lock_ref;
         rd_word[DBG_TX_CLR_BIT] = dbg_q.tx_clear;
         rd_word[DBG_RX_CLR_BIT] = dbg_q.rx_clear;
      end else if (idx == IDX_ALIGN) begin
         rd_word[AL_TX_BIT] = align_s_w.tx_aligned;
         rd_word[AL_RX_BIT] = align_s_w.rx_aligned;
         rd_word[AL_RS_BIT] = HAS_PAM4 & align_s_w.rs_sync;
      end else if (idx == IDX_BLOCK) begin
         rd_word = 32'(block_s);
      end else if (idx == IDX_META) begin
         rd_word = 32'(meta_s);
      end else if (idx == IDX_LANE_CHECKSUM_ERRORS_0) begin
         rd_word = crc_all[31:0];
      end else if (idx == IDX_LANE_CHECKSUM_ERRORS_1) begin
         rd_word = crc_all[63:32];
      end else if (idx == IDX_LANE_CHECKSUM_ERRORS_2) begin
         rd_word = crc_all[95:64];
      end else if (idx == IDX_LANE_CHECKSUM_ERRORS_3) begin
         rd_word = crc_all[127:96];
      end else if (idx == IDX_RXLOSS) begin
         rd_word[FLAG_BIT] = rx_loss_q;
      end else if (idx == IDX_TXLOSS) begin
         rd_word[FLAG_BIT] = tx_loss_q;
      end else if (idx == IDX_INJECT) begin
         rd_word = 32'(inject_q);
      end else if (idx == IDX_TXRDY) begin
         rd_word = HAS_ETILE ? 32'(txrdy_s) : RST_VEC;
      end else if (idx == IDX_RXRDY) begin
         rd_word = HAS_ETILE ? 32'(rxrdy_s) : RST_VEC;
      end else if (idx == IDX_XCODER) begin
         rd_word[FLAG_BIT] = xcoder_q;
      end else if (idx == IDX_UNCOR) begin
         rd_word[FLAG_BIT] = uncor_q;
      end
   end

   always_comb begin
      wr_pend_d = take && HWRITE && hit;
      wr_idx_d = take ? idx : wr_idx_q;
      rd_d = (take && !HWRITE) ? rd_word : rd_q;
      wrap_d = wrap_q;
      dbg_d = dbg_q;
      inject_d = inject_q;
      if (wr_pend_q) begin
         if (wr_idx_q == IDX_WRAP && HAS_WRAP) begin
            wrap_d = HWDATA[NUM_LANES-1:0];
         end else if (wr_idx_q == IDX_DBG) begin
            dbg_d.lock_data = HAS_WRAP & HWDATA[DBG_LOCK_DATA_BIT];
            dbg_d.lock_ref = HAS_WRAP & HWDATA[DBG_LOCK_REF_BIT];
            dbg_d.tx_clear = HWDATA[DBG_TX_CLR_BIT];
            dbg_d.rx_clear = HWDATA[DBG_RX_CLR_BIT];
         end else if (wr_idx_q == IDX_INJECT) begin
            inject_d = HWDATA[NUM_LANES-1:0];
         end
      end
   end

   // a new event in a clearing cycle still lands, so no loss goes unseen
   always_comb begin
      tx_loss_d = EVENTS_IN.tx_loss | (tx_loss_q & ~dbg_q.tx_clear);
      rx_loss_d = EVENTS_IN.rx_loss | (rx_loss_q & ~dbg_q.rx_clear);
      xcoder_d = HAS_PAM4 & (EVENTS_IN.bad_framing | (xcoder_q
                 & ~(wr_pend_q && wr_idx_q == IDX_XCODER && !HWDATA[FLAG_BIT])));
      uncor_d = HAS_PAM4 & (EVENTS_IN.uncor | (uncor_q
                & ~(wr_pend_q && wr_idx_q == IDX_UNCOR && !HWDATA[FLAG_BIT])));
      for (int i = 0; i < MAX_LANES; i++) begin
         cnt_d[i] = cnt_q[i];
         // counters are held at zero for as long as the clear bit stays set
         if (dbg_q.rx_clear) begin
            cnt_d[i] = '0;
         end else if (err_pad[i] && cnt_q[i] != CNT_MAX) begin
            cnt_d[i] = cnt_q[i] + CNT_ONE;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wr_pend_q <= RST_FLAG;
         wr_idx_q <= 8'h00;
         rd_q <= RST_VEC;
         wrap_q <= '0;
         dbg_q <= RST_DBG;
         inject_q <= '0;
         tx_loss_q <= RST_FLAG;
         rx_loss_q <= RST_FLAG;
         xcoder_q <= RST_FLAG;
         uncor_q <= RST_FLAG;
         cnt_q <= '{default: '0};
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q <= wr_idx_d;
         rd_q <= rd_d;
         wrap_q <= wrap_d;
         dbg_q <= dbg_d;
         inject_q <= inject_d;
         tx_loss_q <= tx_loss_d;
         rx_loss_q <= rx_loss_d;
         xcoder_q <= xcoder_d;
         uncor_q <= uncor_d;
         cnt_q <= cnt_d;
      end
   end

   assign HRDATA = rd_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign LANE_WRAP_EN = wrap_q;
   assign DBG_CTRL = dbg_q;
   assign CRC_FAULT_INSERT = inject_q;

   logic rd_take;
   assign rd_take = take && !HWRITE;

   chk_wrap_write: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_WRAP && HAS_WRAP)
      |=> LANE_WRAP_EN == $past(HWDATA[NUM_LANES-1:0]))
      else $error("lane wrap not loaded from write");
   chk_wrap_absent: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      !HAS_WRAP |-> (LANE_WRAP_EN == '0 && !DBG_CTRL.lock_data && !DBG_CTRL.lock_ref))
      else $error("wrap or lock force active in alternate variant");
   chk_lock_data: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_DBG)
      |=> DBG_CTRL.lock_data == (HAS_WRAP & $past(HWDATA[DBG_LOCK_DATA_BIT])))
      else $error("lock to data force wrong");
   chk_lock_ref: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_DBG)
      |=> DBG_CTRL.lock_ref == (HAS_WRAP & $past(HWDATA[DBG_LOCK_REF_BIT])))
      else $error("lock to reference force wrong");
   chk_tx_clear: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (DBG_CTRL.tx_clear && !EVENTS_IN.tx_loss) |=> !tx_loss_q)
      else $error("tx loss flag survived clear");
   chk_rx_clear: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (DBG_CTRL.rx_clear && !EVENTS_IN.rx_loss) |=> (!rx_loss_q && cnt_q[0] == '0))
      else $error("rx state survived clear");
   chk_dbg_reset: assert property (
      @(posedge SYS_CLK)
      !RESETN |=> (DBG_CTRL == RST_DBG && LANE_WRAP_EN == '0))
      else $error("debug control not zero after reset");
   chk_align_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_ALIGN)
      |=> HRDATA[1:0] == $past({align_s_w.rx_aligned, align_s_w.tx_aligned}))
      else $error("alignment bits misread");
   chk_marker_sync: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_ALIGN)
      |=> HRDATA[AL_RS_BIT] == (HAS_PAM4 & $past(align_s_w.rs_sync)))
      else $error("marker sync bit misread");
   chk_block_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_BLOCK) |=> HRDATA == 32'($past(block_s)))
      else $error("block lock vector misread");
   chk_meta_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_META) |=> HRDATA == 32'($past(meta_s)))
      else $error("metaframe vector misread");
   chk_crc_count: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (!DBG_CTRL.rx_clear && CRC_ERR_IN[0])
      |=> cnt_q[0] == (($past(cnt_q[0]) == CNT_MAX) ? CNT_MAX : $past(cnt_q[0]) + CNT_ONE))
      else $error("checksum counter step or saturation wrong");
   chk_rx_loss_set: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      EVENTS_IN.rx_loss |=> rx_loss_q ##1 (rx_loss_q || $past(DBG_CTRL.rx_clear)))
      else $error("rx loss flag not sticky");
   chk_tx_loss_set: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (tx_loss_q && !DBG_CTRL.tx_clear) |=> tx_loss_q)
      else $error("tx loss flag dropped");
   chk_inject_map: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_INJECT)
      |=> CRC_FAULT_INSERT == $past(HWDATA[NUM_LANES-1:0]))
      else $error("inject vector not loaded");
   chk_ready_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && (idx == IDX_TXRDY || idx == IDX_RXRDY) && !HAS_ETILE) |=> HRDATA == RST_VEC)
      else $error("ready vector visible in wrong variant");
   chk_txrdy_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_TXRDY && HAS_ETILE) |=> HRDATA == 32'($past(txrdy_s)))
      else $error("transmit ready vector misread");
   chk_rxrdy_read: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_RXRDY && HAS_ETILE) |=> HRDATA == 32'($past(rxrdy_s)))
      else $error("receive ready vector misread");
   chk_framing_clr: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_XCODER && !HWDATA[FLAG_BIT]
       && !EVENTS_IN.bad_framing) |=> !xcoder_q)
      else $error("framing flag not cleared by zero write");
   chk_uncor_hold: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      EVENTS_IN.uncor |=> (uncor_q == HAS_PAM4))
      else $error("uncorrectable flag not set");
   chk_uncor_clr: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pend_q && wr_idx_q == IDX_UNCOR && !HWDATA[FLAG_BIT]
       && !EVENTS_IN.uncor) |=> !uncor_q)
      else $error("uncorrectable flag not cleared by zero write");
   chk_flag_zero: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (rd_take && idx == IDX_RXLOSS) |=> HRDATA[31:1] == 31'h0)
      else $error("undefined flag bits not zero");
endmodule // ilk_status_regs

/* verification/tb_top.sv */
// self-checking bench for the link status and control register bank
// assumes the bank answers ahb-lite single word transfers and samples status levels
`timescale 1ns/1ps
module tb_top import ilk_regs_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic hsel_p = 1'b0;
   logic tgt_p = 1'b0;
   logic [31:0] hrdata_p;
   logic hreadyout_p;
   logic hresp_p;
   align_s align_in = '0;
   logic [31:0] block_in = 32'h0;
   logic [31:0] meta_in = 32'h0;
   logic [31:0] txrdy_in = 32'h0;
   logic [31:0] rxrdy_in = 32'h0;
   logic [31:0] crc_err = 32'h0;
   event_s events = '0;
   logic [31:0] wrap_en;
   dbg_ctrl_s dbg;
   logic [31:0] fault_ins;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;

   // two slaves share the bus; a stall from either holds the transfer
   assign hready = hreadyout & hreadyout_p;

   ilk_status_regs #(.NUM_LANES(32), .VARIANT(VAR_LH)) i_ilk_status_regs (
      .SYS_CLK(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .ALIGN_IN(align_in), .BLOCK_LOCK_IN(block_in), .META_SYNC_IN(meta_in),
      .TX_CHAN_READY_IN(txrdy_in), .RX_CHAN_READY_IN(rxrdy_in), .CRC_ERR_IN(crc_err),
      .EVENTS_IN(events), .LANE_WRAP_EN(wrap_en), .DBG_CTRL(dbg),
      .CRC_FAULT_INSERT(fault_ins)
   );

   // second bank in the pam4 variant, same bus, own select
   ilk_status_regs #(.NUM_LANES(32), .VARIANT(VAR_E_PAM4)) i_ilk_status_regs_pam4 (
      .SYS_CLK(clk), .RESETN(rst_n), .HSEL(hsel_p), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata_p), .HREADYOUT(hreadyout_p), .HRESP(hresp_p),
      .ALIGN_IN(align_in), .BLOCK_LOCK_IN(block_in), .META_SYNC_IN(meta_in),
      .TX_CHAN_READY_IN(txrdy_in), .RX_CHAN_READY_IN(rxrdy_in), .CRC_ERR_IN(crc_err),
      .EVENTS_IN(events), .LANE_WRAP_EN(), .DBG_CTRL(), .CRC_FAULT_INSERT()
   );

   initial begin
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] ba(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // the master never assumes zero wait states: it waits for ready at both phases
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      hsel <= !tgt_p;
      hsel_p <= tgt_p;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      hsel_p <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = tgt_p ? hrdata_p : hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, ba(idx), d, dummy);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp, "read data");
   endtask

   task automatic pulse(input logic [31:0] mask, input int n);
      repeat (n) begin
         @(posedge clk);
         crc_err <= mask;
         @(posedge clk);
         crc_err <= 32'h0;
      end
   endtask

   task automatic ev_pulse(input event_s e);
      @(posedge clk);
      events <= e;
      @(posedge clk);
      events <= '0;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         $display("BAD %0t run did not finish", $time);
         stop_test();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(ba(IDX_WRAP), 32'h0);
      rd_chk(ba(IDX_DBG), 32'h0);
      rd_chk(ba(IDX_INJECT), 32'h0);
      $display("test reset values done");

      wr(IDX_WRAP, 32'hA5A5_5A5A);
      @(posedge clk);
      chk(wrap_en, 32'hA5A5_5A5A, "wrap enables");
      rd_chk(ba(IDX_WRAP), 32'hA5A5_5A5A);
      wr(IDX_INJECT, 32'h8000_0001);
      @(posedge clk);
      chk(fault_ins, 32'h8000_0001, "fault insert");
      rd_chk(ba(IDX_INJECT), 32'h8000_0001);
      repeat (64) @(posedge clk); // set bits stay up past a metaframe
      wr(IDX_INJECT, 32'h0);
      @(posedge clk);
      chk(fault_ins, 32'h0, "fault insert off");
      $display("test control registers done");

      // only bits 9..6 exist; the rest must drop
      wr(IDX_DBG, 32'hFFFF_FFFF);
      @(posedge clk);
      chk({28'h0, dbg}, 32'hF, "debug controls");
      rd_chk(ba(IDX_DBG), 32'h0000_03C0);
      wr(IDX_DBG, 32'h0);
      @(posedge clk);
      chk({28'h0, dbg}, 32'h0, "debug idle");
      $display("test debug register done");

      align_in <= '{rs_sync: 1'b1, rx_aligned: 1'b1, tx_aligned: 1'b1};
      block_in <= 32'h1234_ABCD;
      meta_in <= 32'hF0F0_0F0F;
      txrdy_in <= 32'hFFFF_FFFF;
      rxrdy_in <= 32'hFFFF_FFFF;
      repeat (6) @(posedge clk);
      rd_chk(ba(IDX_ALIGN), 32'h3);
      rd_chk(ba(IDX_BLOCK), 32'h1234_ABCD);
      rd_chk(ba(IDX_META), 32'hF0F0_0F0F);
      rd_chk(ba(IDX_TXRDY), 32'h0);
      rd_chk(ba(IDX_RXRDY), 32'h0);
      align_in <= '0;
      wr(IDX_ALIGN, 32'hFFFF_FFFF);
      repeat (6) @(posedge clk);
      rd_chk(ba(IDX_ALIGN), 32'h0);
      $display("test status vectors done");

      pulse(32'h0000_0201, 3);
      pulse(32'h0000_0200, 17);
      pulse(32'h8000_0000, 1);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_0), 32'h0000_0003);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_1), 32'h0000_00F0);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_2), 32'h0);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_3), 32'h1000_0000);
      // errors arriving while the clear is held must not survive it
      wr(IDX_DBG, 32'h0000_0040);
      pulse(32'h0000_0001, 2);
      wr(IDX_DBG, 32'h0);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_0), 32'h0);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_1), 32'h0);
      rd_chk(ba(IDX_LANE_CHECKSUM_ERRORS_3), 32'h0);
      $display("test checksum counters done");

      ev_pulse('{rx_loss: 1'b1, tx_loss: 1'b1, bad_framing: 1'b1, uncor: 1'b1});
      repeat (3) @(posedge clk);
      rd_chk(ba(IDX_RXLOSS), 32'h1);
      rd_chk(ba(IDX_TXLOSS), 32'h1);
      rd_chk(ba(IDX_RXLOSS), 32'h1);
      wr(IDX_DBG, 32'h0000_0040);
      wr(IDX_DBG, 32'h0);
      rd_chk(ba(IDX_RXLOSS), 32'h0);
      rd_chk(ba(IDX_TXLOSS), 32'h1);
      wr(IDX_DBG, 32'h0000_0080);
      wr(IDX_DBG, 32'h0);
      rd_chk(ba(IDX_TXLOSS), 32'h0);
      $display("test sticky flags done");

      // the pam4-only flags stay zero in this variant
      rd_chk(ba(IDX_XCODER), 32'h0);
      rd_chk(ba(IDX_UNCOR), 32'h0);
      wr(IDX_XCODER, 32'h0);
      rd_chk(32'h0000_0400, 32'h0);
      rd_chk(ba(IDX_WRAP), 32'hA5A5_5A5A);
      $display("test unmapped and variant done");

      // pam4 bank: no wrap or lock forcing, but ready vectors and fec flags exist
      tgt_p = 1'b1;
      align_in <= '{rs_sync: 1'b1, rx_aligned: 1'b0, tx_aligned: 1'b1};
      rxrdy_in <= 32'h0000_FFFF;
      repeat (6) @(posedge clk);
      rd_chk(ba(IDX_ALIGN), 32'h0000_1001);
      rd_chk(ba(IDX_TXRDY), 32'hFFFF_FFFF);
      rd_chk(ba(IDX_RXRDY), 32'h0000_FFFF);
      wr(IDX_WRAP, 32'hFFFF_FFFF);
      wr(IDX_DBG, 32'h0000_0300);
      rd_chk(ba(IDX_WRAP), 32'h0);
      rd_chk(ba(IDX_DBG), 32'h0);
      ev_pulse('{rx_loss: 1'b0, tx_loss: 1'b0, bad_framing: 1'b1, uncor: 1'b1});
      rd_chk(ba(IDX_XCODER), 32'h1);
      wr(IDX_XCODER, 32'h1);
      rd_chk(ba(IDX_XCODER), 32'h1);
      wr(IDX_XCODER, 32'h0);
      rd_chk(ba(IDX_XCODER), 32'h0);
      rd_chk(ba(IDX_UNCOR), 32'h1);
      wr(IDX_UNCOR, 32'h0);
      rd_chk(ba(IDX_UNCOR), 32'h0);
      chk({30'h0, hresp, hresp_p}, 32'h0, "bus response");
      tgt_p = 1'b0;
      $display("test pam4 variant done");
      stop_test();
   end
endmodule // tb_top
